// *** rtl/l2cp_defines.svh ***
// Register map, field positions, reset values and limits of the secondary-cache policy control block.
`ifndef L2CP_DEFINES_SVH
`define L2CP_DEFINES_SVH

`define L2CP_CC_IDX 8'h52
`define L2CP_ST_IDX 8'h53
`define L2CP_CC_ADDR ({4'h0, `L2CP_CC_IDX, 2'b00})
`define L2CP_ST_ADDR ({4'h0, `L2CP_ST_IDX, 2'b00})
`define L2CP_ADDR_W 14

`define L2CP_SIZE_HI 7
`define L2CP_SIZE_LO 6
`define L2CP_ARR_HI 5
`define L2CP_ARR_LO 4
`define L2CP_NAD_BIT 3
`define L2CP_ECE_BIT 2
`define L2CP_FM_BIT 1
`define L2CP_EN_BIT 0

`define L2CP_RST_LOW 4'h2
`define L2CP_SIZE_NONE 2'h0
`define L2CP_SIZE_256K 2'h1
`define L2CP_SIZE_512K 2'h2
`define L2CP_ARR_ONE 2'h0
`define L2CP_ARR_TWO 2'h3

`define L2CP_LIM64_MASK 32'hFC00_0000
`define L2CP_LIM512_MASK 32'hE000_0000
`define L2CP_UPPER_TAG_MASK 12'h1FF

`define L2CP_STRAP_WAIT 2'h2
`define L2CP_SYNC_STAGES 2

`endif

// *** rtl/l2cp_pkg.sv ***
// Types shared by the secondary-cache policy control block.
package l2cp_pkg;

  typedef struct packed {
    logic [1:0] size;
    logic [1:0] arr;
    logic next_addr_suppress;
    logic ece;
    logic fm;
    logic en;
  } l2cp_cfg_t;

  typedef enum logic [1:0] {
    L2CP_IDLE,
    L2CP_LOOK
  } l2cp_state_t;

  typedef struct packed {
    logic valid;
    logic dirty;
    logic [11:0] tag;
  } l2cp_entry_t;

endpackage : l2cp_pkg

// *** rtl/l2cp_sync.sv ***
// Two-flip-flop level synchroniser.
`timescale 1ns/1ps
module l2cp_sync #(
  parameter int W = 1
) (
  input wire logic i_clk, // Clock.
  input wire logic i_arst_n, // Asynchronous reset, active low.
  input wire logic [W-1:0] i_d, // Asynchronous level in.
  output logic [W-1:0] o_q // Synchronised level out.
);
  logic [W-1:0] s1_r;

  initial begin
    if (W < 1) $error("l2cp_sync: W must be at least 1.");
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1_r <= '0;
      o_q <= '0;
    end else begin
      s1_r <= i_d;
      o_q <= s1_r;
    end
  end
endmodule : l2cp_sync

// *** rtl/l2cp_tag_ram.sv ***
// Line-status and tag memory with a registered read port.
`timescale 1ns/1ps
module l2cp_tag_ram #(
  parameter int DEPTH = 16384,
  parameter int WIDTH = 14
) (
  input wire logic i_clk, // Clock.
  input wire logic i_arst_n, // Asynchronous reset, active low.
  input wire logic i_clr, // Clears all entries, one cycle per entry.
  input wire logic [$clog2(DEPTH)-1:0] i_raddr, // Read index.
  output logic [WIDTH-1:0] o_rdata, // Read data, registered.
  input wire logic i_we, // Write strobe.
  input wire logic [$clog2(DEPTH)-1:0] i_waddr, // Write index.
  input wire logic [WIDTH-1:0] i_wdata, // Write data.
  output logic o_clr_busy // High while the clearing sweep runs.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] clr_idx_r;

  initial begin
    if (DEPTH < 2) $error("l2cp_tag_ram: DEPTH must be at least 2.");
  end

  // Valid bits are cleared by a sweep, since a memory array has no reset.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_clr_busy <= 1'b1;
      clr_idx_r <= '0;
    end else if (i_clr) begin
      o_clr_busy <= 1'b1;
      clr_idx_r <= '0;
    end else if (o_clr_busy) begin
      clr_idx_r <= clr_idx_r + 1'b1;
      if (clr_idx_r == AW'(DEPTH - 1)) o_clr_busy <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (o_clr_busy) begin
      mem[clr_idx_r] <= '0;
    end else if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule : l2cp_tag_ram

// *** rtl/l2cp_top.sv ***
// Secondary-cache policy control: control register, tag lookup and processor cache signalling.
`timescale 1ns/1ps
`include "l2cp_defines.svh"

// Notes on behaviour
// [R1] The arrangement field reads 00 as one pipelined-burst bank, 11 as two banks, 01 and 10 as reserved.
// [R2] With the suppression bit set the next-address output is never asserted.
// [R3] With the suppression bit clear the next-address output depends on arrangement and size.
// [R4] Software sets the suppression bit when the next-address output is unconnected and clears it otherwise.
// [R5] The extended cacheability bit selects a 512-Mbyte limit with upper tag lines on, else 64 Mbytes with them off.
// [R6] The force-miss bit disables hit detection so that an enabled cache handles every cycle as a miss.
// [R7] A populated but disabled cache with force-miss set invalidates the addressed tag entry on each read.
// [R8] With force-miss clear, ordinary hit and miss detection governs each cycle.
// [R9] Software flushes by reading twice the cache size of cacheable memory, then setting force-miss.
// [R10] For a 512-Kbyte cache that read covers 1 Mbyte of non-overlapping 512-Kbyte regions.
// [R11] With cache enable set the processor cache-allow signal is asserted for cacheable memory read cycles.
// [R12] With cache enable clear cache-allow stays negated and no new line fills occur in either level.
// [R13] With cache enable and force-miss both set writes also miss the secondary cache.
// [R14] The secondary cache operates only with a non-zero size field and cache enable set.
// [R15] Leaving reset, the arrangement field takes the inverted strap levels of address pins 29 and 28.
// [R16] A changed field applies to cycles that start after the write; cycles in progress keep the old value.
module l2cp_top
  import l2cp_pkg::*;
#(
  parameter int DEPTH = 16384
) (
  input wire logic i_clk, // Host clock, 100 MHz.
  input wire logic i_arst_n, // Asynchronous reset, active low.
  input wire logic i_psel, // APB select.
  input wire logic i_penable, // APB enable.
  input wire logic i_pwrite, // APB direction, high for write.
  input wire logic [`L2CP_ADDR_W-1:0] i_paddr, // APB byte address.
  input wire logic [31:0] i_pwdata, // APB write data.
  output logic o_pready, // APB ready.
  output logic [31:0] o_prdata, // APB read data.
  output logic o_pslverr, // APB error for unmapped address.
  input wire logic [3:0] i_strap_addr, // Host address pins 31..28 at reset.
  input wire logic i_cyc_valid, // Processor cycle start, one cycle.
  input wire logic i_cyc_write, // Cycle is a write.
  input wire logic i_cyc_mem, // Cycle is a cacheable-type memory cycle.
  input wire logic [31:0] i_cyc_addr, // Cycle address.
  output logic o_cyc_ready, // Block can take a new cycle.
  output logic o_cyc_done, // Lookup result valid, one cycle.
  output logic o_l2_hit, // Secondary-cache hit.
  output logic o_l2_miss, // Secondary-cache miss.
  output logic o_l2_fill, // Line fill into the secondary cache.
  output logic o_tag_inval, // Tag entry invalidated.
  output logic o_cpu_cache_allow_n, // Cache-allow to processor, active low.
  output logic o_next_addr_out_n, // Next-address pipelining, active low.
  output logic o_upper_tag_lines_en, // Upper tag lines 10..8 enabled.
  output logic o_sram_two_bank, // Two banks of pipelined burst SRAM.
  output logic o_l2_active // Secondary cache in operation.
);
  localparam int IW = $clog2(DEPTH);

  initial begin
    if (DEPTH != 16384) $error("l2cp_top: DEPTH must match a 512-Kbyte cache of 32-byte lines.");
  end

  l2cp_cfg_t cfg_r;
  l2cp_cfg_t cyc_cfg_r;
  l2cp_state_t state_r;
  logic [3:0] strap_q;
  logic [1:0] strap_cnt_r;
  logic [31:0] cyc_addr_r;
  logic cyc_write_r;
  logic cyc_mem_r;
  logic [15:0] hit_cnt_r;
  logic [15:0] miss_cnt_r;
  l2cp_entry_t rd_entry;
  l2cp_entry_t wr_entry;
  logic [IW-1:0] rd_idx;
  logic [IW-1:0] cyc_idx;
  logic tag_we;
  logic clr_busy;
  logic [11:0] addr_tag;
  logic [11:0] tag_mask;
  logic populated;
  logic l2_on;
  logic in_limit;
  logic cacheable;
  logic tag_match;
  logic hit;
  logic fill;
  logic inval;
  logic dirty_upd;
  logic ken;
  logic na_en;
  logic apb_wr;
  logic apb_rd;
  logic cc_sel;
  logic st_sel;
  logic [7:0] cc_val;

  // Straps pass two flip-flops before being loaded.
  l2cp_sync #(.W(4)) u_strap_sync (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_d(i_strap_addr),
    .o_q(strap_q)
  );

  l2cp_tag_ram #(.DEPTH(DEPTH), .WIDTH($bits(l2cp_entry_t))) u_tag_ram (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_clr(1'b0),
    .i_raddr(rd_idx),
    .o_rdata(rd_entry),
    .i_we(tag_we),
    .i_waddr(cyc_idx),
    .i_wdata(wr_entry),
    .o_clr_busy(clr_busy)
  );

  // APB slave: zero wait states, error on an unmapped address.
  assign cc_sel = (i_paddr == `L2CP_CC_ADDR);
  assign st_sel = (i_paddr == `L2CP_ST_ADDR);
  assign apb_wr = i_psel && i_penable && i_pwrite;
  // Read data is loaded at the end of the setup phase, so the flop output already stands at the access edge.
  assign apb_rd = i_psel && !i_penable && !i_pwrite;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !cc_sel && !st_sel;
  assign cc_val = {cfg_r.size, cfg_r.arr, cfg_r.next_addr_suppress, cfg_r.ece, cfg_r.fm, cfg_r.en};

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_prdata <= 32'h0000_0000;
    end else if (apb_rd && cc_sel) begin
      o_prdata <= {24'h00_0000, cc_val};
    end else if (apb_rd && st_sel) begin
      o_prdata <= {hit_cnt_r[7:0], miss_cnt_r[7:0], 13'h0000, clr_busy, o_sram_two_bank, o_l2_active};
    end
  end

  // Size and arrangement load the inverted straps once the synchroniser has settled.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      strap_cnt_r <= 2'h0;
    end else if (strap_cnt_r != `L2CP_STRAP_WAIT + 2'h1) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg_r <= l2cp_cfg_t'({4'h0, `L2CP_RST_LOW});
    end else if (strap_cnt_r == `L2CP_STRAP_WAIT) begin
      cfg_r.size <= ~strap_q[3:2];
      cfg_r.arr <= ~strap_q[1:0]; // [R15]
    end else if (apb_wr && cc_sel) begin
      cfg_r.size <= i_pwdata[`L2CP_SIZE_HI:`L2CP_SIZE_LO];
      cfg_r.arr <= i_pwdata[`L2CP_ARR_HI:`L2CP_ARR_LO];
      cfg_r.next_addr_suppress <= i_pwdata[`L2CP_NAD_BIT];
      cfg_r.ece <= i_pwdata[`L2CP_ECE_BIT];
      cfg_r.fm <= i_pwdata[`L2CP_FM_BIT];
      cfg_r.en <= i_pwdata[`L2CP_EN_BIT];
    end
  end

  // Level outputs follow the live register.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_upper_tag_lines_en <= 1'b0;
      o_sram_two_bank <= 1'b0;
      o_l2_active <= 1'b0;
    end else begin
      o_upper_tag_lines_en <= cfg_r.ece; // [R5]
      o_sram_two_bank <= (cfg_r.arr == `L2CP_ARR_TWO); // [R1]
      o_l2_active <= (cfg_r.size != `L2CP_SIZE_NONE) && cfg_r.en; // [R14]
    end
  end

  // Cycle acceptance and configuration snapshot.
  assign o_cyc_ready = (state_r == L2CP_IDLE) && !clr_busy;
  assign rd_idx = (cfg_r.size == `L2CP_SIZE_256K) ? {1'b0, i_cyc_addr[17:5]} : i_cyc_addr[18:5];
  assign cyc_idx = (cyc_cfg_r.size == `L2CP_SIZE_256K) ? {1'b0, cyc_addr_r[17:5]} : cyc_addr_r[18:5];

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r <= L2CP_IDLE;
    end else begin
      case (state_r)
        L2CP_IDLE: begin
          if (i_cyc_valid && o_cyc_ready) state_r <= L2CP_LOOK;
        end
        L2CP_LOOK: begin
          state_r <= L2CP_IDLE;
        end
        default: begin
          state_r <= L2CP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cyc_cfg_r <= l2cp_cfg_t'({4'h0, `L2CP_RST_LOW});
      cyc_addr_r <= 32'h0000_0000;
      cyc_write_r <= 1'b0;
      cyc_mem_r <= 1'b0;
    end else if (i_cyc_valid && o_cyc_ready) begin
      cyc_cfg_r <= cfg_r; // [R16]
      cyc_addr_r <= i_cyc_addr;
      cyc_write_r <= i_cyc_write;
      cyc_mem_r <= i_cyc_mem;
    end
  end

  // Lookup decisions, all taken from the snapshot of the running cycle.
  assign populated = (cyc_cfg_r.size != `L2CP_SIZE_NONE);
  assign l2_on = populated && cyc_cfg_r.en; // [R14]
  assign in_limit = cyc_cfg_r.ece ? ((cyc_addr_r & `L2CP_LIM512_MASK) == 32'h0000_0000)
                                  : ((cyc_addr_r & `L2CP_LIM64_MASK) == 32'h0000_0000); // [R5]
  assign cacheable = cyc_mem_r && in_limit;
  assign addr_tag = cyc_addr_r[29:18];
  assign tag_mask = cyc_cfg_r.ece ? 12'hFFF : `L2CP_UPPER_TAG_MASK; // [R5]
  assign tag_match = rd_entry.valid && ((rd_entry.tag & tag_mask) == (addr_tag & tag_mask));
  assign hit = l2_on && cacheable && !cyc_cfg_r.fm && tag_match; // [R6] [R8] [R13]
  assign fill = l2_on && cacheable && !cyc_cfg_r.fm && !cyc_write_r && !tag_match; // [R12]
  assign inval = populated && !cyc_cfg_r.en && cyc_cfg_r.fm && !cyc_write_r; // [R7]
  assign dirty_upd = hit && cyc_write_r;
  assign ken = cyc_cfg_r.en && cacheable && !cyc_write_r; // [R11] [R12]
  assign tag_we = (state_r == L2CP_LOOK) && (fill || inval || dirty_upd);

  always_comb begin
    wr_entry = rd_entry;
    if (inval) begin
      wr_entry.valid = 1'b0;
      wr_entry.dirty = 1'b0;
    end else if (fill) begin
      wr_entry.valid = 1'b1;
      wr_entry.dirty = 1'b0;
      wr_entry.tag = addr_tag;
    end else if (dirty_upd) begin
      wr_entry.dirty = 1'b1;
    end
  end

  // Next-address is offered for populated, valid arrangements unless suppressed.
  assign na_en = !cfg_r.next_addr_suppress && (cfg_r.size != `L2CP_SIZE_NONE) &&
                 ((cfg_r.arr == `L2CP_ARR_ONE) || (cfg_r.arr == `L2CP_ARR_TWO)); // [R2] [R3]

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_next_addr_out_n <= 1'b1;
    end else begin
      o_next_addr_out_n <= !(i_cyc_valid && o_cyc_ready && na_en); // [R2] [R3]
    end
  end

  // Registered per-cycle results, one cycle after the lookup.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_cyc_done <= 1'b0;
      o_l2_hit <= 1'b0;
      o_l2_miss <= 1'b0;
      o_l2_fill <= 1'b0;
      o_tag_inval <= 1'b0;
      o_cpu_cache_allow_n <= 1'b1;
    end else begin
      o_cyc_done <= (state_r == L2CP_LOOK);
      o_l2_hit <= (state_r == L2CP_LOOK) && hit;
      o_l2_miss <= (state_r == L2CP_LOOK) && l2_on && cacheable && !hit; // [R6]
      o_l2_fill <= (state_r == L2CP_LOOK) && fill;
      o_tag_inval <= (state_r == L2CP_LOOK) && inval; // [R7]
      o_cpu_cache_allow_n <= !((state_r == L2CP_LOOK) && ken); // [R11] [R12]
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hit_cnt_r <= 16'h0000;
      miss_cnt_r <= 16'h0000;
    end else if (state_r == L2CP_LOOK) begin
      if (hit) hit_cnt_r <= hit_cnt_r + 16'h0001;
      if (l2_on && cacheable && !hit) miss_cnt_r <= miss_cnt_r + 16'h0001;
    end
  end

  // Checks.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  sequence start_s;
    i_cyc_valid && o_cyc_ready;
  endsequence

  sequence start_nad_s;
    i_cyc_valid && o_cyc_ready && cfg_r.next_addr_suppress;
  endsequence

  na_suppress_a: assert property (start_nad_s |=> o_next_addr_out_n) // [R2]
    else $error("Next-address asserted while suppressed.");
  na_policy_a: assert property (start_s ##0 (na_en) |=> !o_next_addr_out_n) // [R3]
    else $error("Next-address missing for an eligible cycle.");
  two_bank_a: assert property ($changed(cfg_r.arr) |=> o_sram_two_bank == ($past(cfg_r.arr) == `L2CP_ARR_TWO)) // [R1]
    else $error("Arrangement decode wrong.");
  upper_tag_a: assert property ((state_r == L2CP_LOOK && !cyc_cfg_r.ece &&
                                 (cyc_addr_r & `L2CP_LIM64_MASK) != 32'h0000_0000)
                                |=> !o_l2_hit && !o_l2_fill && o_cpu_cache_allow_n) // [R5]
    else $error("Cycle above the 64-Mbyte limit treated as cacheable.");
  force_miss_a: assert property (start_s ##0 cfg_r.fm |-> ##2 !o_l2_hit && o_cyc_done) // [R6]
    else $error("Hit reported under force-miss.");
  read_inval_a: assert property (start_s ##0 (cfg_r.size != `L2CP_SIZE_NONE && !cfg_r.en && cfg_r.fm && !i_cyc_write)
                                 |-> ##2 o_tag_inval) // [R7]
    else $error("Tag not invalidated on read.");
  normal_lookup_a: assert property ((state_r == L2CP_LOOK && !cyc_cfg_r.fm && l2_on && cacheable && tag_match)
                                    |=> o_l2_hit) // [R8]
    else $error("Hit lost in normal operation.");
  allow_on_a: assert property (start_s ##0 (cfg_r.en && i_cyc_mem && !i_cyc_write && i_cyc_addr[31:26] == 6'h00)
                               |-> ##2 !o_cpu_cache_allow_n) // [R11]
    else $error("Cache-allow missing for a cacheable read.");
  allow_off_a: assert property ((state_r == L2CP_LOOK && !cyc_cfg_r.en) |=> o_cpu_cache_allow_n && !o_l2_fill) // [R12]
    else $error("Cache-allow asserted while disabled.");
  no_fill_a: assert property (o_l2_fill |-> $past(cyc_cfg_r.en) && !$past(cyc_cfg_r.fm)) // [R12] [R13]
    else $error("Fill while disabled or forced.");
  write_miss_a: assert property (o_l2_hit |-> !($past(cyc_cfg_r.en) && $past(cyc_cfg_r.fm))) // [R13]
    else $error("Write hit under enable and force-miss.");
  active_a: assert property (o_l2_active |-> $past(cfg_r.size) != `L2CP_SIZE_NONE && $past(cfg_r.en)) // [R14]
    else $error("Cache active with zero size or disabled.");
  strap_load_a: assert property (strap_cnt_r == `L2CP_STRAP_WAIT |=> cfg_r.arr == ~$past(strap_q[1:0])) // [R15]
    else $error("Arrangement not loaded from straps.");
  snapshot_a: assert property (state_r == L2CP_LOOK |-> cyc_cfg_r == $past(cfg_r)) // [R16]
    else $error("Running cycle did not keep its configuration.");

endmodule : l2cp_top

// *** tb/l2cp_cpu_model.sv ***
// Behavioural host processor that issues cycles to the policy block and captures its answers.
`timescale 1ns/1ps
module l2cp_cpu_model (
  input wire logic i_clk, // Clock.
  input wire logic i_req, // Bench asks for one cycle.
  input wire logic i_wr, // Requested cycle is a write.
  input wire logic i_mem, // Requested cycle is a cacheable-type memory cycle.
  input wire logic [31:0] i_addr, // Requested cycle address.
  input wire logic [3:0] i_dly, // Idle cycles before the start, for slow issue.
  output logic o_ack, // One-cycle pulse when results are captured.
  output logic [6:0] o_res, // Done, hit, miss, fill, invalidate, allow seen, next-address seen.
  output logic o_cyc_valid, // Cycle start to the block.
  output logic o_cyc_write, // Write flag to the block.
  output logic o_cyc_mem, // Memory flag to the block.
  output logic [31:0] o_cyc_addr, // Address to the block.
  input wire logic i_cyc_ready, // Block can take a cycle.
  input wire logic i_cyc_done, // Result valid.
  input wire logic i_hit, // Hit pulse.
  input wire logic i_miss, // Miss pulse.
  input wire logic i_fill, // Fill pulse.
  input wire logic i_inval, // Invalidate pulse.
  input wire logic i_allow_n, // Cache-allow, active low.
  input wire logic i_na_n // Next-address, active low.
);
  int n;
  logic na;
  initial begin
    o_ack = 1'b0;
    o_res = 7'h00;
    o_cyc_valid = 1'b0;
    o_cyc_write = 1'b0;
    o_cyc_mem = 1'b0;
    o_cyc_addr = 32'h0000_0000;
    forever begin
      @(posedge i_clk);
      if (i_req === 1'b1) begin
        repeat (i_dly) @(posedge i_clk);
        o_cyc_valid <= 1'b1;
        o_cyc_write <= i_wr;
        o_cyc_mem <= i_mem;
        o_cyc_addr <= i_addr;
        n = 0;
        do begin
          @(posedge i_clk);
          n++;
        end while (i_cyc_ready !== 1'b1 && n < 20000);
        // Released address lines show the inverse so no stale value can pass for a hold.
        o_cyc_valid <= 1'b0;
        o_cyc_addr <= ~i_addr;
        @(posedge i_clk);
        na = (i_na_n === 1'b0);
        @(posedge i_clk);
        o_res <= {i_cyc_done, i_hit, i_miss, i_fill, i_inval, i_allow_n === 1'b0, na};
        o_ack <= 1'b1;
        @(posedge i_clk);
        o_ack <= 1'b0;
      end
    end
  end
endmodule : l2cp_cpu_model

// *** tb/tb_l2_cache_policy_control.sv ***
// Self-checking bench for the secondary-cache policy control block.
`timescale 1ns/1ps
`include "l2cp_defines.svh"
module tb_l2_cache_policy_control;
  logic i_clk, i_arst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd, raddr, addr_c;
  logic [3:0] strap, rdly;
  logic valid, wr_c, mem_c, ready, done, hit, miss, fill, inval, allow_n, na_n, upper, two, active;
  logic req, rwr, rmem, ack;
  logic [6:0] res;
  int errors, n_checks, n;

  l2cp_top dut_u (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
    .i_strap_addr(strap), .i_cyc_valid(valid), .i_cyc_write(wr_c), .i_cyc_mem(mem_c), .i_cyc_addr(addr_c),
    .o_cyc_ready(ready), .o_cyc_done(done), .o_l2_hit(hit), .o_l2_miss(miss), .o_l2_fill(fill),
    .o_tag_inval(inval), .o_cpu_cache_allow_n(allow_n), .o_next_addr_out_n(na_n),
    .o_upper_tag_lines_en(upper), .o_sram_two_bank(two), .o_l2_active(active));

  l2cp_cpu_model cpu_u (.i_clk(i_clk), .i_req(req), .i_wr(rwr), .i_mem(rmem), .i_addr(raddr), .i_dly(rdly),
    .o_ack(ack), .o_res(res), .o_cyc_valid(valid), .o_cyc_write(wr_c), .o_cyc_mem(mem_c),
    .o_cyc_addr(addr_c), .i_cyc_ready(ready), .i_cyc_done(done), .i_hit(hit), .i_miss(miss),
    .i_fill(fill), .i_inval(inval), .i_allow_n(allow_n), .i_na_n(na_n));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task stop_test;
    $display("errors=%0d checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  task apb(input logic wr, input logic [13:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_clk);
    end while (pready !== 1'b1);
    e = pslverr;
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wcc(input logic [7:0] v);
    apb(1'b1, `L2CP_CC_ADDR, {24'h00_0000, v}, rd, err);
    apb(1'b0, `L2CP_CC_ADDR, 32'h0000_0000, rd, err);
    check(rd, {24'h00_0000, v});
    @(posedge i_clk);
    #1;
  endtask : wcc

  task cyc(input logic w, input logic m, input logic [31:0] a);
    @(posedge i_clk);
    req <= 1'b1;
    rwr <= w;
    rmem <= m;
    raddr <= a;
    @(posedge i_clk);
    req <= 1'b0;
    n = 0;
    while (ack !== 1'b1 && n < 300) begin
      @(posedge i_clk);
      n++;
    end
    check(ack, 1'b1);
    check(res[6], 1'b1);
    #1;
  endtask : cyc

  initial begin
    repeat (60000) @(posedge i_clk);
    errors++;
    stop_test();
  end

  initial begin
    errors = 0;
    n_checks = 0;
    i_arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 14'h0000;
    pwdata = 32'h0000_0000;
    strap = 4'h4;
    req = 1'b0;
    rwr = 1'b0;
    rmem = 1'b0;
    raddr = 32'h0000_0000;
    rdly = 4'h0;
    repeat (10) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (6) @(posedge i_clk);
    apb(1'b0, `L2CP_CC_ADDR, 32'h0000_0000, rd, err);
    check(rd, 32'h0000_00B2);
    check(err, 1'b0);
    check(two, 1'b1);
    check(upper, 1'b0);
    check(active, 1'b0);
    apb(1'b0, 14'h0100, 32'h0000_0000, rd, err);
    check(err, 1'b1);
    n = 0;
    while (ready !== 1'b1 && n < 20000) begin
      @(posedge i_clk);
      n++;
    end
    // Every arrangement with suppression clear and set; software clears it when the output is wired.
    for (int i = 0; i < 8; i++) begin
      wcc({2'h2, i[1:0], i[2], 3'b100});
      check(two, i[1:0] == 2'h3);
      cyc(1'b0, 1'b1, 32'h0000_0040);
      check(res[0], !i[2] && (i[1:0] == 2'h0 || i[1:0] == 2'h3));
    end
    wcc(8'hB5);
    check(active, 1'b1);
    cyc(1'b0, 1'b1, 32'h0001_2340);
    check(res[5:2], 4'b0110);
    check(res[1], 1'b1);
    rdly <= 4'h5;
    cyc(1'b0, 1'b1, 32'h0001_2340);
    check(res[5:4], 2'b10);
    rdly <= 4'h0;
    cyc(1'b0, 1'b0, 32'h0001_2340);
    check(res[1], 1'b0);
    wcc(8'hB7);
    cyc(1'b0, 1'b1, 32'h0001_2340);
    check(res[5:3], 3'b010);
    cyc(1'b1, 1'b1, 32'h0001_2340);
    check(res[5:4], 2'b01);
    wcc(8'hB4);
    check(active, 1'b0);
    cyc(1'b0, 1'b1, 32'h0002_0000);
    check(res[3], 1'b0);
    check(res[1], 1'b0);
    check(res[2], 1'b0);
    wcc(8'hB6);
    cyc(1'b0, 1'b1, 32'h0001_2340);
    check(res[2], 1'b1);
    cyc(1'b1, 1'b1, 32'h0001_2340);
    check(res[2], 1'b0);
    wcc(8'hB5);
    cyc(1'b0, 1'b1, 32'h0001_2340);
    check(res[5:4], 2'b01);
    wcc(8'hB1);
    check(upper, 1'b0);
    cyc(1'b0, 1'b1, 32'h0800_0000);
    check(res[3], 1'b0);
    check(res[1], 1'b0);
    wcc(8'hB5);
    cyc(1'b0, 1'b1, 32'h0800_0000);
    check(res[1], 1'b1);
    // Flush: the same lines of two non-overlapping 512-Kbyte regions, only the first few to keep the run short.
    for (int j = 0; j < 4; j++) begin
      cyc(1'b0, 1'b1, 32'h0000_0020 * j);
      check(res[3], 1'b1);
      cyc(1'b0, 1'b1, 32'h0008_0000 + 32'h0000_0020 * j);
      check(res[3], 1'b1);
    end
    wcc(8'hB7);
    cyc(1'b0, 1'b1, 32'h0008_0000);
    check(res[5:4], 2'b01);
    wcc(8'h35);
    check(active, 1'b0);
    cyc(1'b0, 1'b1, 32'h0003_0000);
    check(res[3], 1'b0);
    check(res[0], 1'b0);
    stop_test();
  end
endmodule : tb_l2_cache_policy_control
